// ---- core/periodic_timebase_interrupt.sv ----
// Periodic timebase with control register, interrupt status and low-power handling
//
// What this block does
// - Divider held at zero while run enable is clear; counts from zero once set.
// - Divider chain has fifteen stages, eight offered as selectable taps.
// - Rollover at the selected tap sets the read-only rollover flag.
// - Flag set with interrupt enable raises the CPU interrupt request.
// - Writing one to acknowledge clears the flag unless a rollover comes in the same cycle; zero does nothing; reads zero.
// - First flag after enable comes at half period, later ones at full period.
// - Rate codes 0 to 7 divide by 32768,8192,2048,128,64,32,16,8.
// - Configuration bit adds divide-by-128 ahead of the chain.
// - Interrupt period is the divide ratio over the input clock frequency.
// - Counting continues in wait; control register unreachable in wait.
// - In stop, runs only if oscillator kept running; register unreachable in stop.
// - Active in stop, the periodic interrupt serves as a stop wakeup.
// - Reset clears run enable and interrupt enable.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps

module periodic_timebase_interrupt
  import timebase_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              oscillator_clock,
  input  wire logic              extra_prescale_select,
  input  wire logic              oscillator_in_stop_enable,
  input  wire logic              wait_mode,
  input  wire logic              stop_mode,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   cpu_irq,
  output logic                   stop_wakeup,
  output logic                   irq_out
);

  // Oscillator pin synchroniser and edge detect
  logic                     osc_sync1_reg;
  logic                     osc_sync2_reg;
  logic                     osc_prev_reg;
  logic                     osc_tick;

  // Control register state
  logic                     run_enable_reg;
  logic                     rollover_irq_enable_reg;
  logic [RATE_SELECT_W-1:0] rate_select_reg;
  logic                     rollover_flag_reg;

  // Interrupt status and mask
  logic [EVT_W-1:0]         evt_status_reg;
  logic [EVT_W-1:0]         evt_mask_reg;
  logic [EVT_W-1:0]         evt_set;
  logic [EVT_W-1:0]         evt_clear;

  // Bus decode
  logic                     bus_open;
  logic                     ctrl_wr;
  logic                     status_wr;
  logic                     mask_wr;
  logic                     ack_wr;
  logic                     halted;
  logic                     rollover;
  logic [DATA_W-1:0]        read_value;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_prev_reg  <= 1'b0;
    end else begin
      osc_sync1_reg <= oscillator_clock;
      osc_sync2_reg <= osc_sync1_reg;
      osc_prev_reg  <= osc_sync2_reg;
    end
  end

  // one count per oscillator rising edge
  assign osc_tick = osc_sync2_reg && !osc_prev_reg;

  // halt in stop unless oscillator kept running
  assign halted = stop_mode && !oscillator_in_stop_enable;

  // register closed in wait and stop
  assign bus_open  = !wait_mode && !stop_mode;
  assign ctrl_wr   = reg_wr && bus_open && (reg_addr == TIMEBASE_CONTROL_OFS);
  assign status_wr = reg_wr && bus_open && (reg_addr == IRQ_STATUS_OFS);
  assign mask_wr   = reg_wr && bus_open && (reg_addr == IRQ_MASK_OFS);
  assign ack_wr    = ctrl_wr && reg_wdata[FLAG_ACK_BIT];

  timebase_divider #(
    .STAGES(CHAIN_STAGES)
  ) u_divider (
    .core_clk              (core_clk),
    .sys_rst               (sys_rst),
    .run_enable            (run_enable_reg),
    .halted                (halted),
    .osc_tick              (osc_tick),
    .extra_prescale_select (extra_prescale_select),
    .rate_select           (rate_select_reg),
    .rollover              (rollover)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_enable_reg          <= 1'b0;
      rollover_irq_enable_reg <= 1'b0;
    end else if (ctrl_wr) begin
      run_enable_reg          <= reg_wdata[RUN_ENABLE_BIT];
      rollover_irq_enable_reg <= reg_wdata[ROLLOVER_IRQ_EN_BIT];
    end
  end

  // rate field of the control register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rate_select_reg <= RATE_SELECT_RST;
    end else if (ctrl_wr) begin
      rate_select_reg <= reg_wdata[RATE_SELECT_LSB +: RATE_SELECT_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rollover_flag_reg <= 1'b0;
    end else if (rollover) begin
      rollover_flag_reg <= 1'b1;
    end else if (ack_wr) begin
      rollover_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpu_irq <= 1'b0;
    end else begin
      cpu_irq <= rollover_flag_reg && rollover_irq_enable_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stop_wakeup <= 1'b0;
    end else begin
      stop_wakeup <= stop_mode && !halted && rollover_flag_reg && rollover_irq_enable_reg;
    end
  end

  // Sticky events
  always_comb begin
    evt_set                      = '0;
    evt_set[EVT_ROLLOVER_BIT]    = rollover;
    evt_set[EVT_STOP_WAKEUP_BIT] = rollover && stop_mode;
    evt_set[EVT_RATE_CHANGE_BIT] = ctrl_wr && run_enable_reg &&
                                   (reg_wdata[RATE_SELECT_LSB +: RATE_SELECT_W] != rate_select_reg);
  end

  assign evt_clear = status_wr ? reg_wdata[EVT_W-1:0] : '0;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      evt_status_reg <= EVT_RST;
    end else begin
      evt_status_reg <= (evt_status_reg & ~evt_clear) | evt_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      evt_mask_reg <= MASK_RST;
    end else if (mask_wr) begin
      evt_mask_reg <= reg_wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_status_reg & evt_mask_reg);
    end
  end

  // Read mux; acknowledge reads as zero
  always_comb begin
    read_value = '0;
    if (bus_open) begin
      case (reg_addr)
        TIMEBASE_CONTROL_OFS: begin
          read_value[ROLLOVER_FLAG_BIT]                       = rollover_flag_reg;
          read_value[RATE_SELECT_LSB +: RATE_SELECT_W]        = rate_select_reg;
          read_value[ROLLOVER_IRQ_EN_BIT]                     = rollover_irq_enable_reg;
          read_value[RUN_ENABLE_BIT]                          = run_enable_reg;
        end
        IRQ_STATUS_OFS: begin
          read_value[EVT_W-1:0] = evt_status_reg;
        end
        IRQ_MASK_OFS: begin
          read_value[EVT_W-1:0] = evt_mask_reg;
        end
        default: begin
          read_value = '0;
        end
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= read_value;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // periodic_timebase_interrupt

// ---- core/timebase_divider.sv ----
// Prescaler and fifteen-stage divider chain with selectable rollover tap
`timescale 1ns/10ps

module timebase_divider
  import timebase_pkg::*;
#(
  parameter int unsigned STAGES = CHAIN_STAGES
) (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     run_enable,
  input  wire logic                     halted,
  input  wire logic                     osc_tick,
  input  wire logic                     extra_prescale_select,
  input  wire logic [RATE_SELECT_W-1:0] rate_select,
  output logic                          rollover
);

  logic [PRESCALE_W-1:0] prescale_reg;
  logic [STAGES-1:0]     chain_reg;
  logic                  stage_tick;
  logic [TAP_W-1:0]      tap_msb;
  logic [STAGES-1:0]     low_mask;
  logic                  tap_hit;

  // Extra divide-by-128 ahead of the chain
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run_enable) begin
      prescale_reg <= '0;
    end else if (osc_tick && !halted && extra_prescale_select) begin
      prescale_reg <= prescale_reg + 7'h01;
    end
  end

  assign stage_tick = osc_tick && !halted &&
                      (!extra_prescale_select || (prescale_reg == PRESCALE_LAST));

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run_enable) begin
      chain_reg <= '0;
    end else if (stage_tick) begin
      chain_reg <= chain_reg + {{(STAGES-1){1'b0}}, 1'b1};
    end
  end

  assign tap_msb  = TAP_MSB_TABLE[{rate_select, 2'b00} +: TAP_W];
  assign low_mask = (STAGES'(1) << tap_msb) - STAGES'(1);

  // tap bit rising gives half period first, full period after
  assign tap_hit = stage_tick && ((chain_reg & low_mask) == low_mask) && !chain_reg[tap_msb];

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run_enable) begin
      rollover <= 1'b0;
    end else begin
      rollover <= tap_hit;
    end
  end

endmodule // timebase_divider

// ---- core/timebase_pkg.sv ----
// Constants for the periodic timebase: register map, field layout, divider taps
package timebase_pkg;

  // Register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] TIMEBASE_CONTROL_OFS = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFS       = 4'h1;
  localparam logic [3:0] IRQ_MASK_OFS         = 4'h2;

  // Control register field positions
  localparam int unsigned ROLLOVER_FLAG_BIT    = 7;
  localparam int unsigned RATE_SELECT_LSB      = 4;
  localparam int unsigned RATE_SELECT_W        = 3;
  localparam int unsigned FLAG_ACK_BIT         = 3;
  localparam int unsigned ROLLOVER_IRQ_EN_BIT  = 2;
  localparam int unsigned RUN_ENABLE_BIT       = 1;

  // Status and mask bit positions
  localparam int unsigned EVT_ROLLOVER_BIT     = 0;
  localparam int unsigned EVT_STOP_WAKEUP_BIT  = 1;
  localparam int unsigned EVT_RATE_CHANGE_BIT  = 2;
  localparam int unsigned EVT_W                = 3;

  // Reset values
  localparam logic [2:0] RATE_SELECT_RST = 3'h0;
  localparam logic [2:0] EVT_RST         = 3'h0;
  localparam logic [2:0] MASK_RST        = 3'h0;

  // Divider structure
  localparam int unsigned CHAIN_STAGES   = 15;
  localparam int unsigned PRESCALE_W     = 7;
  localparam logic [6:0]  PRESCALE_LAST  = 7'h7f;
  localparam int unsigned TAP_W          = 4;

  // Highest counter bit below each tap, one nibble per rate code, code 0 lowest.
  // Codes 0..7 give ratios 2^15, 2^13, 2^11, 2^7, 2^6, 2^5, 2^4, 2^3.
  localparam logic [31:0] TAP_MSB_TABLE = {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc, 4'he};

endpackage : timebase_pkg

// ---- tb/periodic_timebase_interrupt_asserts.sv ----
// Port checker for the periodic timebase
`timescale 1ns/10ps

module periodic_timebase_interrupt_asserts
  import timebase_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       oscillator_clock,
  input wire logic       oscillator_in_stop_enable,
  input wire logic       wait_mode,
  input wire logic       stop_mode,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       cpu_irq,
  input wire logic       stop_wakeup,
  input wire logic       irq_out
);
  logic [5:0] osc_hist;
  logic       open;
  logic       quiet;

  // No oscillator edge for six cycles, so no rollover can race an acknowledge
  always_ff @(posedge core_clk) begin
    osc_hist <= {osc_hist[4:0], oscillator_clock};
  end
  assign open  = !wait_mode && !stop_mode;
  assign quiet = (osc_hist == 6'h00) || (osc_hist == 6'h3f);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  chk_read_pulse: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_blocked_read: assert property ($past(reg_rd && !open) |-> reg_rdata == 8'h00)
    else $error("read answered in low power mode");
  chk_ack_reads_zero: assert property ($past(reg_rd && reg_addr == 4'h0) |-> !reg_rdata[FLAG_ACK_BIT])
    else $error("acknowledge bit read as one");
  chk_unmapped_zero: assert property ($past(reg_rd && reg_addr > 4'h2) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($past(sys_rst) |-> !cpu_irq && !irq_out && !stop_wakeup)
    else $error("output active after reset");
  chk_wake_in_stop: assert property (stop_wakeup |-> $past(stop_mode && oscillator_in_stop_enable))
    else $error("wakeup outside running stop");
  chk_wake_with_irq: assert property (stop_wakeup |-> cpu_irq)
    else $error("wakeup without interrupt");
  chk_ack_drops_irq: assert property (reg_wr && open && reg_addr == 4'h0 && reg_wdata[FLAG_ACK_BIT] && quiet
    |-> ##2 !cpu_irq)
    else $error("interrupt kept after acknowledge");
  chk_mask_silences: assert property ((reg_wr && open && reg_addr == 4'h2 && reg_wdata[2:0] == 3'h0) ##1 !reg_wr
    |-> ##1 !irq_out)
    else $error("interrupt output while fully masked");

  cover property ($rose(cpu_irq));
  cover property ($rose(stop_wakeup));
  cover property ($fell(irq_out));
endmodule // periodic_timebase_interrupt_asserts

// ---- tb/tb_periodic_timebase_interrupt.sv ----
// Self-checking bench for the periodic timebase
`timescale 1ns/10ps

module tb_periodic_timebase_interrupt
  import timebase_pkg::*;
();
  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       oscillator_clock = 1'b0;
  logic       extra_prescale_select = 1'b0;
  logic       oscillator_in_stop_enable = 1'b0;
  logic       wait_mode = 1'b0;
  logic       stop_mode = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       cpu_irq;
  logic       stop_wakeup;
  logic       irq_out;
  logic [7:0] ctl = 8'h00;
  int         miscompares = 0;
  int         checks = 0;
  int unsigned ratio [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

  periodic_timebase_interrupt DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .oscillator_clock(oscillator_clock),
    .extra_prescale_select(extra_prescale_select), .oscillator_in_stop_enable(oscillator_in_stop_enable),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_irq(cpu_irq),
    .stop_wakeup(stop_wakeup), .irq_out(irq_out)
  );

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
    @(posedge core_clk);
    #1;
  endtask

  // Each oscillator period spans four core cycles, then the pipeline settles
  task automatic osc(input int n);
    repeat (n) begin
      oscillator_clock <= 1'b1;
      repeat (2) @(posedge core_clk);
      oscillator_clock <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task automatic stop_test();
    if (miscompares == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    rd(4'h0, 8'h00, "control at reset");
    rd(4'h2, 8'h00, "mask at reset");
    rd(4'h5, 8'h00, "unmapped read");
    wr(4'h2, 8'h01);
    for (int code = 0; code < 8; code++) begin
      // stop at the old rate, then restart
      wr(4'h0, (ctl & 8'h70) | 8'h08);
      ctl = 8'h06 | (8'(code) << RATE_SELECT_LSB);
      wr(4'h0, ctl);
      osc(ratio[code] / 2 - 1);
      rd(4'h0, ctl, "flag before half period");
      osc(1);
      rd(4'h0, ctl | 8'h80, "flag at selected tap");
      check("cpu_irq", {7'h00, cpu_irq}, 8'h01);
    end
    wr(4'h0, 8'h7e);
    rd(4'h0, 8'h76, "flag after acknowledge");
    check("cpu_irq after ack", {7'h00, cpu_irq}, 8'h00);
    osc(7);
    rd(4'h0, 8'h76, "flag before full period");
    osc(1);
    rd(4'h0, 8'hf6, "flag at full period");
    wr(4'h0, 8'h76);
    rd(4'h0, 8'hf6, "flag after zero ack");
    rd(4'h1, 8'h01, "rollover status");
    check("irq_out unmasked", {7'h00, irq_out}, 8'h01);
    wr(4'h2, 8'h00);
    check("irq_out masked", {7'h00, irq_out}, 8'h00);
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h00, "status cleared");
    wr(4'h0, 8'h7e);
    wait_mode <= 1'b1;
    osc(8);
    wr(4'h0, 8'h08);
    rd(4'h0, 8'h00, "read in wait");
    wait_mode <= 1'b0;
    rd(4'h0, 8'hf6, "counting in wait");
    wr(4'h0, 8'h7e);
    stop_mode <= 1'b1;
    osc(8);
    oscillator_in_stop_enable <= 1'b1;
    osc(7);
    check("wakeup halted count", {7'h00, stop_wakeup}, 8'h00);
    osc(1);
    check("wakeup in stop", {7'h00, stop_wakeup}, 8'h01);
    stop_mode <= 1'b0;
    rd(4'h1, 8'h03, "status after stop");
    extra_prescale_select <= 1'b1;
    wr(4'h0, 8'h78);
    wr(4'h0, 8'h72);
    osc(511);
    rd(4'h0, 8'h72, "prescaled before half");
    osc(1);
    rd(4'h0, 8'hf2, "prescaled at half");
    check("cpu_irq disabled", {7'h00, cpu_irq}, 8'h00);
    wr(4'h0, 8'h78);
    extra_prescale_select <= 1'b0;
    wait_mode <= 1'b1;
    osc(8);
    wait_mode <= 1'b0;
    rd(4'h0, 8'h70, "stopped through wait");
    wr(4'h0, 8'h76);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    rd(4'h0, 8'h00, "control after reset");
    rd(4'h1, 8'h00, "status after reset");
    stop_test();
  end
endmodule // tb_periodic_timebase_interrupt

bind periodic_timebase_interrupt periodic_timebase_interrupt_asserts chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .oscillator_clock(oscillator_clock),
  .oscillator_in_stop_enable(oscillator_in_stop_enable), .wait_mode(wait_mode), .stop_mode(stop_mode),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_irq(cpu_irq), .stop_wakeup(stop_wakeup), .irq_out(irq_out)
);
